/* logic/usi_top.sv */
`timescale 1ns/1ps
module usi_top
  import usi_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic [3:0] ADDR_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic [7:0] WDATA_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       INTR_ACK_I,
  output logic            INT_O,
  input  wire logic [7:0] IRQ_SRC_I,
  input  wire logic [1:0] CHAR_LEN_I,
  input  wire logic [1:0] STOP_BITS_I,
  input  wire logic       PARITY_ENABLE_I,
  input  wire logic       EVEN_PARITY_SELECT_I,
  input  wire logic [3:0] BAUD_SEL_I,
  input  wire logic       TEST_MODE_I,
  input  wire logic       BREAK_IN_ENABLE_I,
  input  wire logic       PORT1_BIT4_DIR_I,
  input  wire logic       SW_RESET_I,
  input  wire logic       RXD_I,
  input  wire logic       CTS_N_I,
  input  wire logic       PORT1_BIT6_I,
  output logic            TXD_O,
  output logic            PORT1_BIT4_O,
  output logic            PORT1_BIT4_OE_O
);
  // Pin synchronisers: rxd, cts_n, port1_bit6
  logic [2:0] sync1, sync2, sync3, pin;
  logic [2:0] next_pin;
  logic rxd, cts_n, brk_in_pin;

  // Baud generator
  logic [15:0] bdiv, next_bdiv;
  logic        bclk, next_bclk;
  logic        tick;
  logic [7:0]  bit_len;
  logic        gen_on;

  // Transmitter
  usi_tx_t     tx_st, next_tx_st;
  logic [7:0]  tx_ctr, next_tx_ctr;
  logic [2:0]  tx_bit, next_tx_bit;
  logic [7:0]  tx_shift, next_tx_shift;
  logic [7:0]  tx_buf, next_tx_buf;
  logic        tx_par, next_tx_par;
  logic        txd, next_txd;
  logic        brk_in_seen, next_brk_in_seen;
  logic        tx_evt;
  logic [7:0]  stop_len;

  // Receiver
  usi_rx_t     rx_st, next_rx_st;
  logic [7:0]  rx_ctr, next_rx_ctr;
  logic [2:0]  rx_bit, next_rx_bit;
  logic [7:0]  rx_shift, next_rx_shift;
  logic [7:0]  rx_buf, next_rx_buf;
  logic        rx_par, next_rx_par;
  logic        rx_zero, next_rx_zero;
  logic        rx_prev, next_rx_prev;
  logic        tx_seen, next_tx_seen;
  logic        rx_evt;

  // Status, enables, requests, register port
  logic [7:0]  status, next_status;
  logic [7:0]  ien, next_ien;
  logic [7:0]  irr, next_irr;
  logic [7:0]  modifier, next_modifier;
  logic [7:0]  rdata, next_rdata;
  logic        int_q, next_int_q;
  logic [2:0]  top_lvl;
  logic        top_any;
  logic        ack;
  logic        rd_status;

  assign rxd        = pin[0];
  assign cts_n      = pin[1];
  assign brk_in_pin = pin[2];

  always_comb begin
    next_pin = pin;
    for (int i = 0; i < 3; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_pin[i] = sync3[i];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    sync1 <= {PORT1_BIT6_I, CTS_N_I, RXD_I};
    sync2 <= sync1;
    sync3 <= sync2;
    if (SYS_RST_I) begin
      pin <= 3'h7;
    end else begin
      pin <= next_pin;
    end
  end

  // Baud generator: toggles at twice the tick rate; a tick is each rising edge
  assign gen_on  = (BAUD_SEL_I >= BAUD_SEL_MIN);
  assign bit_len = (BAUD_SEL_I == BAUD_SEL_FAST) ? BIT_TICKS_FAST : BIT_TICKS;
  assign tick    = gen_on && (bdiv == 16'h0000) && !bclk;

  always_comb begin
    next_bdiv = bdiv;
    next_bclk = bclk;
    if (!gen_on) begin
      next_bdiv = 16'h0000;
      next_bclk = 1'b0;
    end else if (bdiv == 16'h0000) begin
      next_bdiv = 16'(usi_half_div(BAUD_SEL_I) - 16'h0001);
      next_bclk = !bclk;
    end else begin
      next_bdiv = 16'(bdiv - 16'h0001);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      bdiv <= 16'h0000;
      bclk <= 1'b0;
    end else begin
      bdiv <= next_bdiv;
      bclk <= next_bclk;
    end
  end

  assign PORT1_BIT4_OE_O = PORT1_BIT4_DIR_I;
  assign PORT1_BIT4_O    = TEST_MODE_I && gen_on && PORT1_BIT4_DIR_I && bclk; // R1

  // Transmitter
  assign stop_len = (STOP_BITS_I == 2'h0) ? bit_len :
                    (STOP_BITS_I == 2'h1) ? 8'(bit_len + (bit_len >> 1)) : 8'(bit_len << 1);

  always_comb begin
    next_tx_st       = tx_st;
    next_tx_ctr      = tx_ctr;
    next_tx_bit      = tx_bit;
    next_tx_shift    = tx_shift;
    next_tx_buf      = tx_buf;
    next_tx_par      = tx_par;
    next_txd         = txd;
    next_brk_in_seen = brk_in_seen;
    next_status      = status;
    tx_evt           = 1'b0;
    if (WR_I && ADDR_I == OFS_DATA) begin
      next_tx_buf                = WDATA_I & usi_char_mask(CHAR_LEN_I); // R9 R8
      next_status[ST_BUF_EMPTY]  = 1'b0; // R18
    end
    if (status[ST_SHIFT_EMPTY] && !status[ST_BUF_EMPTY] && !cts_n && tx_st == USI_TX_IDLE) begin
      next_tx_shift               = tx_buf; // R7
      next_tx_par                 = !EVEN_PARITY_SELECT_I;
      next_status[ST_SHIFT_EMPTY] = 1'b0; // R17
      next_status[ST_BUF_EMPTY]   = 1'b1; // R18
      tx_evt                      = 1'b1; // R19
      next_tx_st                  = USI_TX_START;
      next_tx_ctr                 = 8'h00;
      next_txd                    = 1'b0;
      next_brk_in_seen            = 1'b0;
    end else if (tick && tx_st != USI_TX_IDLE) begin
      next_tx_ctr = 8'(tx_ctr + 8'h01);
      if (tx_st == USI_TX_STOP && tx_ctr >= 8'(stop_len - bit_len)
          && BREAK_IN_ENABLE_I && !brk_in_pin) begin
        next_brk_in_seen = 1'b1; // R2
      end
      case (tx_st)
        USI_TX_START: begin
          if (tx_ctr == 8'(bit_len - 8'h01)) begin
            next_tx_st  = USI_TX_DATA;
            next_tx_ctr = 8'h00;
            next_tx_bit = 3'h0;
            next_txd    = tx_shift[0];
          end
        end
        USI_TX_DATA: begin
          if (tx_ctr == 8'(bit_len - 8'h01)) begin
            next_tx_ctr   = 8'h00;
            next_tx_par   = tx_par ^ tx_shift[0];
            next_tx_shift = {1'b0, tx_shift[7:1]};
            if (tx_bit == 3'(CHAR_LEN_I) + 3'h4) begin
              next_tx_st = PARITY_ENABLE_I ? USI_TX_PAR : USI_TX_STOP;
              next_txd   = PARITY_ENABLE_I ? (tx_par ^ tx_shift[0]) : 1'b1;
            end else begin
              next_tx_bit = 3'(tx_bit + 3'h1);
              next_txd    = tx_shift[1];
            end
          end
        end
        USI_TX_PAR: begin
          if (tx_ctr == 8'(bit_len - 8'h01)) begin
            next_tx_st  = USI_TX_STOP;
            next_tx_ctr = 8'h00;
            next_txd    = 1'b1;
          end
        end
        USI_TX_STOP: begin
          if (tx_ctr == 8'(stop_len - 8'h01)) begin
            next_tx_st                  = USI_TX_IDLE;
            next_status[ST_SHIFT_EMPTY] = 1'b1; // R17
            tx_evt                      = status[ST_BUF_EMPTY]; // R19
            if (brk_in_seen || (BREAK_IN_ENABLE_I && !brk_in_pin)) begin
              next_status[ST_BREAK] = 1'b1; // R16
              tx_evt                = 1'b1; // R16
            end
          end
        end
        default: next_tx_st = USI_TX_IDLE;
      endcase
    end
    // Receiver and status
    next_rx_st    = rx_st;
    next_rx_ctr   = rx_ctr;
    next_rx_bit   = rx_bit;
    next_rx_shift = rx_shift;
    next_rx_buf   = rx_buf;
    next_rx_par   = rx_par;
    next_rx_zero  = rx_zero;
    next_rx_prev  = rxd;
    next_tx_seen  = tx_seen || (tx_st != USI_TX_IDLE);
    rx_evt        = 1'b0;
    rd_status     = RD_I && ADDR_I == OFS_STATUS;
    // Read clears are applied first so that any set below wins
    if (rd_status) begin
      next_status[ST_OVERRUN] = 1'b0; // R13 R25
      next_status[ST_PARITY]  = 1'b0; // R14 R25
      next_status[ST_BREAK]   = 1'b0; // R16 R25
      if (!modifier[MOD_ECHO]) begin
        next_status[ST_FRAMING] = 1'b0; // R10 R12 R25
      end
    end
    if (SW_RESET_I) begin
      next_status[ST_OVERRUN] = 1'b0; // R13
      next_status[ST_BREAK]   = 1'b0; // R16
    end
    if (RD_I && ADDR_I == OFS_DATA) begin
      next_status[ST_BUF_FULL] = 1'b0; // R6
    end
    if (rx_st == USI_RX_IDLE || rx_st == USI_RX_WAIT) begin
      if (rx_prev && !rxd) begin
        next_rx_st   = USI_RX_START; // R15
        next_rx_ctr  = 8'h00;
        next_tx_seen = (tx_st != USI_TX_IDLE);
      end
    end else if (tick) begin
      next_rx_ctr = 8'(rx_ctr + 8'h01);
      if (rx_st == USI_RX_START && rx_ctr == 8'((bit_len >> 1) - 8'h01)) begin
        next_rx_ctr   = 8'h00;
        next_rx_bit   = 3'h0;
        next_rx_par   = !EVEN_PARITY_SELECT_I;
        next_rx_zero  = 1'b1;
        next_rx_shift = 8'h00;
        next_rx_st    = (rxd && !modifier[MOD_START_OFF]) ? USI_RX_IDLE : USI_RX_DATA; // R22
      end else if (rx_st != USI_RX_START && rx_ctr == 8'(bit_len - 8'h01)) begin
        next_rx_ctr  = 8'h00;
        next_rx_zero = rx_zero && !rxd;
        next_rx_par  = rx_par ^ rxd;
        case (rx_st)
          USI_RX_DATA: begin
            next_rx_shift = {rxd, rx_shift[7:1]};
            if (rx_bit == 3'(CHAR_LEN_I) + 3'h4) begin
              next_rx_shift = 8'({rxd, rx_shift[7:1]} >> (2'h3 - CHAR_LEN_I));
              next_rx_st    = PARITY_ENABLE_I ? USI_RX_PAR : USI_RX_STOP;
            end else begin
              next_rx_bit = 3'(rx_bit + 3'h1);
            end
          end
          USI_RX_PAR: begin
            next_rx_st = USI_RX_STOP;
          end
          USI_RX_STOP: begin
            rx_evt       = 1'b1; // R19
            next_rx_st   = USI_RX_IDLE;
            next_tx_seen = (tx_st != USI_TX_IDLE);
            if (rx_zero && !rxd) begin
              next_status[ST_BREAK] = 1'b1; // R15
              next_rx_st            = USI_RX_WAIT; // R15
            end else begin
              next_rx_buf              = rx_shift & usi_char_mask(CHAR_LEN_I); // R9
              next_status[ST_BUF_FULL] = 1'b1; // R6
              if (status[ST_BUF_FULL] && !(RD_I && ADDR_I == OFS_DATA)) begin
                next_status[ST_OVERRUN] = 1'b1; // R13
              end
              if (PARITY_ENABLE_I && rx_par) begin
                next_status[ST_PARITY] = 1'b1; // R14
              end
              if (modifier[MOD_ECHO]) begin
                next_status[ST_FRAMING] = tx_seen || (tx_st != USI_TX_IDLE); // R12 R22
              end else if (!rxd) begin
                next_status[ST_FRAMING] = 1'b1; // R10
              end
              if (!rxd) begin
                // Low stop bit serves as the start bit of the next character
                next_rx_st    = USI_RX_DATA; // R11
                next_rx_bit   = 3'h0;
                next_rx_par   = !EVEN_PARITY_SELECT_I;
                next_rx_zero  = 1'b1;
                next_rx_shift = 8'h00;
              end
            end
          end
          default: next_rx_st = USI_RX_IDLE;
        endcase
      end
    end
  end

  // Interrupt controller
  always_comb begin
    top_lvl = 3'h0;
    top_any = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (irr[i] && ien[i]) begin
        top_lvl = 3'(i); // R4
        top_any = 1'b1;
      end
    end
  end

  assign ack = INTR_ACK_I || (RD_I && ADDR_I == OFS_INT_CLEAR); // R5

  always_comb begin
    next_ien      = ien;
    next_irr      = irr;
    next_modifier = modifier;
    next_rdata    = rdata;
    if (WR_I && ADDR_I == OFS_INT_ENABLE) begin
      next_ien = ien | WDATA_I; // R3
    end else if (WR_I && ADDR_I == OFS_INT_CLEAR) begin
      next_ien = ien & ~WDATA_I; // R3
    end
    if (WR_I && ADDR_I == OFS_STATUS) begin
      next_modifier = WDATA_I;
    end
    if (ack && top_any) begin
      next_irr[top_lvl] = 1'b0; // R5 R20
    end
    next_irr         = next_irr | (IRQ_SRC_I & ~8'h30);
    next_irr[LVL_RX] = next_irr[LVL_RX] | rx_evt; // R19
    next_irr[LVL_TX] = next_irr[LVL_TX] | tx_evt; // R18 R19
    next_int_q       = |(next_irr & next_ien); // R20
    if (RD_I) begin
      if (ADDR_I == OFS_INT_ENABLE) begin
        next_rdata = ien; // R3
      end else if (ADDR_I == OFS_INT_CLEAR) begin
        next_rdata = 8'({top_lvl, {IADDR_SHIFT{1'b0}}}); // R5
      end else if (ADDR_I == OFS_DATA) begin
        next_rdata = rx_buf; // R9
      end else if (ADDR_I == OFS_STATUS) begin
        next_rdata = {int_q, status[6:0]}; // R21 R25
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      tx_st       <= USI_TX_IDLE;
      tx_ctr      <= 8'h00;
      tx_bit      <= 3'h0;
      tx_shift    <= 8'h00;
      tx_buf      <= 8'h00;
      tx_par      <= 1'b0;
      txd         <= 1'b1; // R23
      brk_in_seen <= 1'b0;
      rx_st       <= USI_RX_IDLE;
      rx_ctr      <= 8'h00;
      rx_bit      <= 3'h0;
      rx_shift    <= 8'h00;
      rx_buf      <= 8'h00;
      rx_par      <= 1'b0;
      rx_zero     <= 1'b0;
      rx_prev     <= 1'b1;
      tx_seen     <= 1'b0;
      status      <= 8'h30; // R23 R17 R18
      ien         <= IEN_RESET;
      irr         <= 8'h00;
      modifier    <= MOD_RESET; // R24
      rdata       <= 8'h00;
      int_q       <= 1'b0;
    end else begin
      tx_st       <= next_tx_st;
      tx_ctr      <= next_tx_ctr;
      tx_bit      <= next_tx_bit;
      tx_shift    <= next_tx_shift;
      tx_buf      <= next_tx_buf;
      tx_par      <= next_tx_par;
      txd         <= next_txd;
      brk_in_seen <= next_brk_in_seen;
      rx_st       <= next_rx_st;
      rx_ctr      <= next_rx_ctr;
      rx_bit      <= next_rx_bit;
      rx_shift    <= next_rx_shift;
      rx_buf      <= next_rx_buf;
      rx_par      <= next_rx_par;
      rx_zero     <= next_rx_zero;
      rx_prev     <= next_rx_prev;
      tx_seen     <= next_tx_seen;
      status      <= next_status;
      ien         <= next_ien;
      irr         <= next_irr;
      modifier    <= next_modifier;
      rdata       <= next_rdata;
      int_q       <= next_int_q;
    end
  end

  assign TXD_O   = txd;
  assign INT_O   = int_q;
  assign RDATA_O = rdata;
endmodule

/* logic/usi_pkg.sv */
// How it works
// [R1] Test mode drives baud clock on port1_bit4
// [R2] Port1_bit6 low during last stop: break-in
// [R3] Set/clear masks change enables; readback shows enables
// [R4] Level 0 highest, 4 receive, 5 transmit
// [R5] Address read returns level times four, acknowledges
// [R6] Buffer full flag set at stop, cleared
// [R7] Transmit byte waits for empty shifter, CTS low
// [R8] Host writes data only while buffer empty
// [R9] Unused upper bits zero on read, ignored
// [R10] Framing flag on bad stop, read clears
// [R11] Bad low stop bit becomes next start
// [R12] Echo mode: framing flag shows transmitter activity
// [R13] Overrun on unread buffer, read or reset clears
// [R14] Parity checked only when enabled, read clears
// [R15] Received break flags, level 4, not loaded
// [R16] Break-in flags, level 5, read or reset clears
// [R17] Shift-empty set at end, cleared on load
// [R18] Buffer-empty set on transfer, cleared by write
// [R19] Receive events at stop; transmit events at empties
// [R20] Pending bit mirrors interrupt pin, ack clears
// [R21] Status layout, readable any time
// [R22] Start check disable; echo mode hides framing
// [R23] Hardware reset: flags clear except empties, line high
// [R24] Hardware reset clears modifier; software reset not
// [R25] Read clears flag only after returning it; a break-in set in the same cycle as a status read is cleared unreturned
package usi_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam logic [3:0]  OFS_INT_ENABLE  = 4'h5;
  localparam logic [3:0]  OFS_INT_CLEAR   = 4'h6;
  localparam logic [3:0]  OFS_DATA        = 4'h7;
  localparam logic [3:0]  OFS_STATUS      = 4'hF;
  localparam int          ST_FRAMING      = 0;
  localparam int          ST_OVERRUN      = 1;
  localparam int          ST_PARITY       = 2;
  localparam int          ST_BREAK        = 3;
  localparam int          ST_SHIFT_EMPTY  = 4;
  localparam int          ST_BUF_EMPTY    = 5;
  localparam int          ST_BUF_FULL     = 6;
  localparam int          ST_INT          = 7;
  localparam int          MOD_START_OFF   = 0;
  localparam int          MOD_ECHO        = 1;
  localparam int          LVL_RX          = 4;
  localparam int          LVL_TX          = 5;
  localparam logic [7:0]  IEN_RESET       = 8'h00;
  localparam logic [7:0]  MOD_RESET       = 8'h00;
  localparam logic [7:0]  BIT_TICKS       = 8'h40;
  localparam logic [7:0]  BIT_TICKS_FAST  = 8'h20;
  localparam logic [3:0]  BAUD_SEL_MIN    = 4'h3;
  localparam logic [3:0]  BAUD_SEL_FAST   = 4'h3;
  localparam int          IADDR_SHIFT     = 2;

  typedef enum logic [2:0] {
    USI_TX_IDLE  = 3'b000,
    USI_TX_START = 3'b001,
    USI_TX_DATA  = 3'b010,
    USI_TX_PAR   = 3'b011,
    USI_TX_STOP  = 3'b100
  } usi_tx_t;

  typedef enum logic [2:0] {
    USI_RX_IDLE  = 3'b000,
    USI_RX_START = 3'b001,
    USI_RX_DATA  = 3'b010,
    USI_RX_PAR   = 3'b011,
    USI_RX_STOP  = 3'b100,
    USI_RX_WAIT  = 3'b101
  } usi_rx_t;

  // Half period of the baud generator clock in system cycles
  function automatic logic [15:0] usi_half_div(input logic [3:0] sel);
    int unsigned rate;
    int unsigned mult;
    rate = 0;
    mult = (sel == BAUD_SEL_FAST) ? 32'd32 : 32'd64;
    case (sel)
      4'h3: rate = 19200;
      4'h4: rate = 9600;
      4'h5: rate = 4800;
      4'h6: rate = 2400;
      4'h7: rate = 1200;
      4'h8: rate = 600;
      4'h9: rate = 300;
      4'hA: rate = 200;
      4'hB: rate = 150;
      4'hC: rate = 110;
      4'hD: rate = 100;
      4'hE: rate = 75;
      default: rate = 50;
    endcase
    return 16'(CLK_HZ / (rate * mult * 2));
  endfunction

  function automatic logic [7:0] usi_char_mask(input logic [1:0] len);
    return 8'(8'hFF >> (2'h3 - len));
  endfunction
endpackage

/* test/usi_top_checker.sv */
`timescale 1ns/1ps
module usi_top_checker
  import usi_pkg::*;
(
  input wire logic       CLK_I,
  input wire logic       SYS_RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] WDATA_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       INT_O,
  input wire logic [1:0] CHAR_LEN_I,
  input wire logic [3:0] BAUD_SEL_I,
  input wire logic       TEST_MODE_I,
  input wire logic       PORT1_BIT4_DIR_I,
  input wire logic       TXD_O,
  input wire logic       PORT1_BIT4_O,
  input wire logic       PORT1_BIT4_OE_O
);
  localparam logic [7:0] HALF_FAST = 8'(CLK_HZ / (19200 * 32 * 2));
  logic       fast_cfg;
  logic [7:0] cfg_age;
  logic [7:0] next_cfg_age;
  logic [7:0] hi_cnt;
  logic [7:0] next_hi_cnt;

  assign fast_cfg = TEST_MODE_I && (BAUD_SEL_I == BAUD_SEL_FAST) && PORT1_BIT4_DIR_I;

  // Age of the fast test setup and length of the current high phase of the baud clock
  always_comb begin
    next_cfg_age = !fast_cfg ? 8'h00 : (cfg_age == 8'hFF) ? cfg_age : cfg_age + 8'h01;
    next_hi_cnt  = PORT1_BIT4_O ? hi_cnt + 8'h01 : 8'h00;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cfg_age <= 8'h00;
      hi_cnt  <= 8'h00;
    end else begin
      cfg_age <= next_cfg_age;
      hi_cnt  <= next_hi_cnt;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_wr_set;
    WR_I && ADDR_I == OFS_INT_ENABLE;
  endsequence
  sequence s_wr_clr;
    WR_I && ADDR_I == OFS_INT_CLEAR;
  endsequence
  sequence s_rd_en;
    RD_I && ADDR_I == OFS_INT_ENABLE;
  endsequence

  property p_rst_out;
    $fell(SYS_RST_I) |-> TXD_O && !INT_O;
  endproperty
  property p_set_mask;
    s_wr_set ##2 s_rd_en |=> (RDATA_O & $past(WDATA_I, 3)) == $past(WDATA_I, 3);
  endproperty
  property p_clr_mask;
    s_wr_clr ##2 s_rd_en |=> (RDATA_O & $past(WDATA_I, 3)) == 8'h00;
  endproperty
  property p_iaddr;
    RD_I && ADDR_I == OFS_INT_CLEAR |=> RDATA_O[1:0] == 2'h0 && RDATA_O[7:5] == 3'h0;
  endproperty
  property p_int_bit;
    (RD_I && ADDR_I == OFS_STATUS) ##1 $stable(INT_O) |-> RDATA_O[ST_INT] == INT_O;
  endproperty
  property p_rd_hold;
    !RD_I |=> $stable(RDATA_O);
  endproperty
  property p_unmapped;
    RD_I && (ADDR_I < 4'h5 || (ADDR_I > 4'h7 && ADDR_I < 4'hF)) |=> RDATA_O == 8'h00;
  endproperty
  property p_short_rd;
    RD_I && ADDR_I == OFS_DATA && CHAR_LEN_I == 2'h0 |=> RDATA_O[7:5] == 3'h0;
  endproperty
  property p_bclk_half;
    $fell(PORT1_BIT4_O) && cfg_age == 8'hFF |-> hi_cnt == HALF_FAST;
  endproperty
  property p_bclk_off;
    !TEST_MODE_I [*3] |-> !PORT1_BIT4_O;
  endproperty
  property p_oe;
    PORT1_BIT4_OE_O == PORT1_BIT4_DIR_I;
  endproperty

  a_rst_out: assert property (p_rst_out) else $error("line or interrupt wrong after reset");
  a_set_mask: assert property (p_set_mask) else $error("set mask bits not enabled");
  a_clr_mask: assert property (p_clr_mask) else $error("clear mask bits still enabled");
  a_iaddr: assert property (p_iaddr) else $error("interrupt address not level times four");
  a_int_bit: assert property (p_int_bit) else $error("status pending bit differs from pin");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_short_rd: assert property (p_short_rd) else $error("unused receive bits not zero");
  a_bclk_half: assert property (p_bclk_half) else $error("baud clock half period wrong");
  a_bclk_off: assert property (p_bclk_off) else $error("baud clock out of test mode");
  a_oe: assert property (p_oe) else $error("pin enable differs from direction");
endmodule

bind usi_top usi_top_checker u_chk (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
  .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .INT_O(INT_O), .CHAR_LEN_I(CHAR_LEN_I),
  .BAUD_SEL_I(BAUD_SEL_I), .TEST_MODE_I(TEST_MODE_I), .PORT1_BIT4_DIR_I(PORT1_BIT4_DIR_I),
  .TXD_O(TXD_O), .PORT1_BIT4_O(PORT1_BIT4_O), .PORT1_BIT4_OE_O(PORT1_BIT4_OE_O)
);

/* test/usi_line_peer.sv */
`timescale 1ns/1ps
module usi_line_peer #(
  parameter int BIT_CYCLES = 5184
) (
  input  wire logic clk_i,
  output logic      rxd_o,
  output logic      cts_n_o,
  output logic      sense_n_o
);
  // Line rests at marking level with no break-in sensed
  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b0;
    sense_n_o = 1'b1;
  end

  task automatic set_cts(input logic v);
    @(posedge clk_i);
    #1;
    cts_n_o = v;
  endtask

  task automatic set_sense(input logic v);
    @(posedge clk_i);
    #1;
    sense_n_o = v;
  endtask

  // Bits go out LSB first, start bit included
  task automatic send_frame(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      #1;
      rxd_o = bits[i];
      repeat (BIT_CYCLES - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    #1;
    rxd_o = 1'b1;
  endtask
endmodule

/* test/test_uart_status_interrupt.sv */
`timescale 1ns/1ps
module test_uart_status_interrupt;
  import usi_pkg::*;
  localparam int HALF = CLK_HZ / (19200 * 32 * 2);
  localparam int BIT  = 2 * HALF * 32;
  logic       clk, rst, wr, rd, ack, par_en, even_par, test_mode, brk_en, p14_dir, sw_rst;
  logic       rxd, cts_n, sense_n, txd, int_o, p14, p14_oe;
  logic [3:0] addr, baud_sel;
  logic [7:0] wdata, rdata, irq_src, seen;
  logic [1:0] char_len, stop_bits;
  int         fail_count, compares, n;

  usi_top dut (
    .CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WR_I(wr), .RD_I(rd), .WDATA_I(wdata),
    .RDATA_O(rdata), .INTR_ACK_I(ack), .INT_O(int_o), .IRQ_SRC_I(irq_src), .CHAR_LEN_I(char_len),
    .STOP_BITS_I(stop_bits), .PARITY_ENABLE_I(par_en), .EVEN_PARITY_SELECT_I(even_par),
    .BAUD_SEL_I(baud_sel), .TEST_MODE_I(test_mode), .BREAK_IN_ENABLE_I(brk_en),
    .PORT1_BIT4_DIR_I(p14_dir), .SW_RESET_I(sw_rst), .RXD_I(rxd), .CTS_N_I(cts_n),
    .PORT1_BIT6_I(sense_n), .TXD_O(txd), .PORT1_BIT4_O(p14), .PORT1_BIT4_OE_O(p14_oe)
  );
  usi_line_peer #(.BIT_CYCLES(BIT)) peer (.clk_i(clk), .rxd_o(rxd), .cts_n_o(cts_n), .sense_n_o(sense_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cyc(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc();
    wr = 1'b0;
    cyc();
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] msk = 8'hFF);
    addr = a;
    rd = 1'b1;
    cyc();
    rd = 1'b0;
    seen = rdata;
    chk(seen & msk, exp);
    cyc();
  endtask

  task automatic wait_lvl(input logic v);
    n = 0;
    while (p14 !== v && n < 400) begin
      cyc();
      n++;
    end
  endtask

  // Follows one transmitted frame at bit centres: start, data, even parity, stop
  task automatic tx_expect(input logic [7:0] wd);
    logic [6:0] exp;
    exp = {1'b1, ^wd[4:0], wd[4:0]};
    n = 0;
    while (txd !== 1'b0 && n < 40) begin
      cyc();
      n++;
    end
    rd_chk(OFS_STATUS, 8'h20, 8'h7F);
    cyc(BIT / 2 - 2);
    chk({7'h00, txd}, 8'h00);
    for (int i = 0; i < 7; i++) begin
      cyc(BIT);
      chk({7'h00, txd}, {7'h00, exp[i]});
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    fail_count = 0;
    compares = 0;
    rst = 1'b1;
    {wr, rd, ack, test_mode, brk_en, p14_dir, sw_rst} = 7'h00;
    {par_en, even_par} = 2'h3;
    addr = 4'h0;
    wdata = 8'h00;
    irq_src = 8'h00;
    char_len = 2'h0;
    stop_bits = 2'h0;
    baud_sel = 4'h3;
    cyc(10);
    rst = 1'b0;
    chk({6'h00, txd, int_o}, 8'h02);
    rd_chk(OFS_STATUS, 8'h30);
    rd_chk(OFS_INT_ENABLE, 8'h00);
    rd_chk(4'h0, 8'h00);
    sw_rst = 1'b1;
    cyc();
    sw_rst = 1'b0;
    cyc();
    rd_chk(OFS_STATUS, 8'h30);
    $display("reset test done");

    p14_dir = 1'b1;
    test_mode = 1'b1;
    cyc(300);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    chk(8'(n), 8'(HALF));
    chk({7'h00, p14_oe}, 8'h01);
    test_mode = 1'b0;
    cyc(5);
    chk({7'h00, p14}, 8'h00);
    $display("baud clock test done");

    wr_reg(OFS_INT_ENABLE, 8'hFF);
    rd_chk(OFS_INT_ENABLE, 8'hFF);
    wr_reg(OFS_INT_CLEAR, 8'h3E);
    rd_chk(OFS_INT_ENABLE, 8'hC1);
    irq_src = 8'hC1;
    cyc();
    irq_src = 8'h00;
    cyc(3);
    chk({7'h00, int_o}, 8'h01);
    rd_chk(OFS_INT_CLEAR, 8'h00);
    rd_chk(OFS_INT_CLEAR, 8'h18);
    rd_chk(OFS_STATUS, 8'hB0);
    ack = 1'b1;
    cyc();
    ack = 1'b0;
    cyc(2);
    chk({7'h00, int_o}, 8'h00);
    wr_reg(OFS_INT_CLEAR, 8'hFF);
    wr_reg(OFS_INT_ENABLE, 8'h30);
    $display("interrupt test done");

    peer.set_cts(1'b1);
    cyc(10);
    rd_chk(OFS_STATUS, 8'h30);
    wr_reg(OFS_DATA, 8'hF5);
    cyc(100);
    chk({7'h00, txd}, 8'h01);
    rd_chk(OFS_STATUS, 8'h10);
    brk_en = 1'b1;
    peer.set_sense(1'b0);
    peer.set_cts(1'b0);
    fork
      peer.send_frame(16'h009A, 8);
      tx_expect(8'hF5);
    join
    cyc(BIT);
    peer.set_sense(1'b1);
    rd_chk(OFS_STATUS, 8'hFC);
    rd_chk(OFS_STATUS, 8'hF0);
    rd_chk(OFS_INT_CLEAR, 8'h10);
    rd_chk(OFS_INT_CLEAR, 8'h14);
    cyc(2);
    chk({7'h00, int_o}, 8'h00);
    rd_chk(OFS_DATA, 8'h0D);
    rd_chk(OFS_STATUS, 8'h30);
    $display("serial test done");
    tally_and_finish();
  end
endmodule
